// ### rtl/clkbank_consts.svh
// Register offsets, field positions, reset values and codes of the output bank registers
`ifndef CLKBANK_CONSTS_SVH
`define CLKBANK_CONSTS_SVH

// Bank C register offsets
`define ADDR_C_CTRL   8'h22
`define ADDR_C_OUT0   8'h24
`define ADDR_C_OUT1   8'h25

// Bank D register offsets
`define ADDR_FRAC_LO  8'h28
`define ADDR_FRAC_MID 8'h29
`define ADDR_FRAC_HI  8'h2a
`define ADDR_FINT     8'h2b
`define ADDR_D_DIV    8'h2c
`define ADDR_D_SEL    8'h2d
`define ADDR_D_PWR    8'h2e
`define ADDR_D_RSVD   8'h2f
`define ADDR_D_OUT0   8'h30
`define ADDR_D_OUT1   8'h31

// Field positions inside a byte register
`define BIT_PD        7
`define BIT_SRC       0
`define BIT_STY       2
`define BIT_DIVKIND   1
`define BIT_MUXSRC    0
`define AMP_HI        1
`define AMP_LO        0
`define POSTDIV_HI    3
`define POSTDIV_LO    2
`define FINT_HI       3
`define DIV_HI        5

// Reset values
`define RST_FRAC      24'h600000
`define RST_FINT      4'h9
`define RST_DDIV      6'h0d
`define RST_BYTE      8'h00

// Amplitude codes, single-ended swing
`define AMP_350MV     2'h0
`define AMP_500MV     2'h1
`define AMP_750MV     2'h2
`define AMP_RSVD      2'h3

// Output style codes
`define STY_LVDS      1'h0
`define STY_LVPECL    1'h1

`endif

// ### rtl/clkbank_pkg.sv
// Types shared by the output bank configuration logic
package clkbank_pkg;

   typedef logic [1:0] amp_t;

   // Bank C settings, from pins or from registers
   typedef struct packed {
      logic       bankPd;
      logic [1:0] pd;
      logic [1:0] sty;
      amp_t       amp1;
      amp_t       amp0;
   } bankCCfg_t;

   // Bank D settings, from pins or from registers
   typedef struct packed {
      logic [5:0]  divCode;
      logic [3:0]  fracInt;
      logic [23:0] frac;
      logic [1:0]  postDiv;
      logic        divKind;
      logic        muxSrc;
      logic        bankPd;
      logic        out0Pd;
      logic        out1Pd;
      logic        sty0;
      amp_t        amp0;
   } bankDCfg_t;

   // Byte access from the serial port engine
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } regReq_t;

endpackage : clkbank_pkg

// ### rtl/bank_source_select.sv
// Registered choice between pin-derived and register settings of one bank
`timescale 1ns/10ps
module bank_source_select #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         useReg,
   input  wire logic [W-1:0] pinVal,
   input  wire logic [W-1:0] regVal,
   output logic      [W-1:0] selVal
);

   logic [W-1:0] sel_r;
   logic [W-1:0] sel_nxt;

   // Pick the active source
   always_comb
   begin
      sel_nxt = useReg ? regVal : pinVal;
   end

   // Hold the applied settings
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         sel_r <= '0;
      else
         sel_r <= sel_nxt;
   end

   assign selVal = sel_r;

endmodule : bank_source_select

// ### rtl/clock_output_bank_config_regs.sv
// Configuration registers and source selection for clock output banks C and D
//
// Summary of operation
// - Bank C source bit 0 uses pins, 1 uses registers; resets to 0.
// - Each bank C output powers down when its power-down bit is 1.
// - Bank C output style bit: 0 drives LVDS, 1 drives LVPECL.
// - Bank C amplitude: 00 350 mV, 01 500 mV, 10 750 mV, 11 reserved.
// - Reserved bits are written zero by host; device reads them as zero.
// - Fraction is the 24-bit field over 2^24, low byte first, reset 600000h.
// - Integer part 5h to Fh divides by value; 0h to 4h reserved; reset 1001b.
// - Total fractional ratio is integer part plus the fraction.
// - Bank D source bit 0 uses pins, 1 uses registers.
// - Bank D power-down powers bank and first output down, second output high-Z.
`timescale 1ns/10ps
`include "clkbank_consts.svh"
module clock_output_bank_config_regs
   import clkbank_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire regReq_t     regReq,
   output logic      [7:0]  regRdata,
   output logic             regRdValid,
   input  wire bankCCfg_t   pinCfgC,
   input  wire bankDCfg_t   pinCfgD,
   output bankCCfg_t        effCfgC,
   output bankDCfg_t        effCfgD,
   output logic             bankCOut0Off,
   output logic             bankCOut1Off,
   output logic             bankDOut0Off,
   output logic             bankDOut1HiZ,
   output logic      [27:0] fracRatio
);

   // ************************************************************
   // Register storage
   // ************************************************************

   bankCCfg_t  cReg_r;
   bankCCfg_t  cReg_nxt;
   bankDCfg_t  dReg_r;
   bankDCfg_t  dReg_nxt;
   logic       cSrc_r;
   logic       cSrc_nxt;
   logic       dSrc_r;
   logic       dSrc_nxt;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic       rdValid_r;
   logic       rdValid_nxt;
   logic [7:0] wd;

   assign wd = regReq.wdata;

   // Write decode; only defined bits are stored
   always_comb
   begin
      cReg_nxt = cReg_r;
      dReg_nxt = dReg_r;
      cSrc_nxt = cSrc_r;
      dSrc_nxt = dSrc_r;
      if (regReq.wr)
      begin
         case (regReq.addr)
            `ADDR_C_CTRL:
            begin
               cReg_nxt.bankPd = wd[`BIT_PD];
               cSrc_nxt        = wd[`BIT_SRC];
            end
            `ADDR_C_OUT0:
            begin
               cReg_nxt.pd[0] = wd[`BIT_PD];
               cReg_nxt.sty[0] = wd[`BIT_STY];
               cReg_nxt.amp0  = wd[`AMP_HI:`AMP_LO];
            end
            `ADDR_C_OUT1:
            begin
               cReg_nxt.pd[1] = wd[`BIT_PD];
               cReg_nxt.sty[1] = wd[`BIT_STY];
               cReg_nxt.amp1  = wd[`AMP_HI:`AMP_LO];
            end
            `ADDR_FRAC_LO:  dReg_nxt.frac[7:0]   = wd;
            `ADDR_FRAC_MID: dReg_nxt.frac[15:8]  = wd;
            `ADDR_FRAC_HI:  dReg_nxt.frac[23:16] = wd;
            `ADDR_FINT:     dReg_nxt.fracInt     = wd[`FINT_HI:0];
            `ADDR_D_DIV:    dReg_nxt.divCode     = wd[`DIV_HI:0];
            `ADDR_D_SEL:
            begin
               dReg_nxt.postDiv = wd[`POSTDIV_HI:`POSTDIV_LO];
               dReg_nxt.divKind = wd[`BIT_DIVKIND];
               dReg_nxt.muxSrc  = wd[`BIT_MUXSRC];
            end
            `ADDR_D_PWR:
            begin
               dReg_nxt.bankPd = wd[`BIT_PD];
               dSrc_nxt        = wd[`BIT_SRC];
            end
            `ADDR_D_OUT0:
            begin
               dReg_nxt.out0Pd = wd[`BIT_PD];
               dReg_nxt.sty0   = wd[`BIT_STY];
               dReg_nxt.amp0   = wd[`AMP_HI:`AMP_LO];
            end
            `ADDR_D_OUT1:   dReg_nxt.out1Pd = wd[`BIT_PD];
            default:
            begin
               cReg_nxt = cReg_r;                                   // Unmapped: ignored
            end
         endcase
      end
   end

   // Read mux; reserved bits and unmapped bytes read zero
   always_comb
   begin
      rdValid_nxt = regReq.rd;
      rdData_nxt  = `RST_BYTE;
      if (regReq.rd)
      begin
         case (regReq.addr)
            `ADDR_C_CTRL:   rdData_nxt = {cReg_r.bankPd, 6'h00, cSrc_r};
            `ADDR_C_OUT0:   rdData_nxt = {cReg_r.pd[0], 4'h0, cReg_r.sty[0], cReg_r.amp0};
            `ADDR_C_OUT1:   rdData_nxt = {cReg_r.pd[1], 4'h0, cReg_r.sty[1], cReg_r.amp1};
            `ADDR_FRAC_LO:  rdData_nxt = dReg_r.frac[7:0];
            `ADDR_FRAC_MID: rdData_nxt = dReg_r.frac[15:8];
            `ADDR_FRAC_HI:  rdData_nxt = dReg_r.frac[23:16];
            `ADDR_FINT:     rdData_nxt = {4'h0, dReg_r.fracInt};
            `ADDR_D_DIV:    rdData_nxt = {2'h0, dReg_r.divCode};
            `ADDR_D_SEL:    rdData_nxt = {4'h0, dReg_r.postDiv, dReg_r.divKind,
                                          dReg_r.muxSrc};
            `ADDR_D_PWR:    rdData_nxt = {dReg_r.bankPd, 6'h00, dSrc_r};
            `ADDR_D_OUT0:   rdData_nxt = {dReg_r.out0Pd, 4'h0, dReg_r.sty0, dReg_r.amp0};
            `ADDR_D_OUT1:   rdData_nxt = {dReg_r.out1Pd, 7'h00};
            default:        rdData_nxt = `RST_BYTE;
         endcase
      end
   end

   // Register update and reset values
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cReg_r         <= '0;
         cSrc_r         <= 1'h0;
         dSrc_r         <= 1'h0;
         dReg_r         <= '0;
         dReg_r.frac    <= `RST_FRAC;
         dReg_r.fracInt <= `RST_FINT;
         dReg_r.divCode <= `RST_DDIV;
         rdData_r       <= `RST_BYTE;
         rdValid_r      <= 1'h0;
      end
      else
      begin
         cReg_r    <= cReg_nxt;
         dReg_r    <= dReg_nxt;
         cSrc_r    <= cSrc_nxt;
         dSrc_r    <= dSrc_nxt;
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   assign regRdata   = rdData_r;
   assign regRdValid = rdValid_r;

   // ************************************************************
   // Source selection and applied settings
   // ************************************************************

   // Bank C pin or register control
   bank_source_select #(.W($bits(bankCCfg_t))) selC (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .useReg  (cSrc_r),
      .pinVal  (pinCfgC),
      .regVal  (cReg_r),
      .selVal  (effCfgC)
   );

   // Bank D pin or register control
   bank_source_select #(.W($bits(bankDCfg_t))) selD (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .useReg  (dSrc_r),
      .pinVal  (pinCfgD),
      .regVal  (dReg_r),
      .selVal  (effCfgD)
   );

   // Output power states from the applied settings
   assign bankCOut0Off = effCfgC.pd[0];
   assign bankCOut1Off = effCfgC.pd[1];
   assign bankDOut0Off = effCfgD.bankPd | effCfgD.out0Pd;
   assign bankDOut1HiZ = effCfgD.bankPd | effCfgD.out1Pd;

   // Ratio as 4.24 fixed point: integer part plus fraction over 2^24
   assign fracRatio = {effCfgD.fracInt, effCfgD.frac};

   // ************************************************************
   // Assertions
   // ************************************************************

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Write decodes used by the assertions
   logic wrCOut0;
   logic wrCOut1;
   logic wrDOut0;
   logic keepC;
   logic keepD;

   // Strobes per target byte
   assign wrCOut0 = regReq.wr && regReq.addr == `ADDR_C_OUT0;
   assign wrCOut1 = regReq.wr && regReq.addr == `ADDR_C_OUT1;
   assign wrDOut0 = regReq.wr && regReq.addr == `ADDR_D_OUT0;
   assign keepC   = !(regReq.wr && regReq.addr == `ADDR_C_CTRL);
   assign keepD   = !(regReq.wr && regReq.addr == `ADDR_D_PWR);

   a_c_pin_source: assert property (!cSrc_r |=> effCfgC == $past(pinCfgC))
      else $error("Bank C not following pins");

   a_c_pd_write: assert property (cSrc_r && keepC && wrCOut0 ##1 cSrc_r
      |=> bankCOut0Off == $past(wd[`BIT_PD], 2))
      else $error("Bank C output 0 power-down not applied");

   a_c_style_write: assert property (cSrc_r && keepC && wrCOut0 ##1 cSrc_r
      |=> effCfgC.sty[0] == $past(wd[`BIT_STY], 2))
      else $error("Bank C output 0 style not applied");

   a_c_amp_write: assert property (cSrc_r && keepC && wrCOut0 ##1 cSrc_r
      |=> effCfgC.amp0 == $past(wd[`AMP_HI:`AMP_LO], 2))
      else $error("Bank C output 0 amplitude not applied");

   a_rsvd_read_zero: assert property (regReq.rd && regReq.addr == `ADDR_D_RSVD
      |=> regRdValid && regRdata == 8'h00)
      else $error("Reserved byte did not read zero");

   a_frac_hi_store: assert property (regReq.wr && regReq.addr == `ADDR_FRAC_HI
      |=> dReg_r.frac[23:16] == $past(wd))
      else $error("Fraction high byte not stored");

   a_fint_ratio: assert property (dSrc_r && keepD && regReq.wr
      && regReq.addr == `ADDR_FINT ##1 dSrc_r
      |=> fracRatio[27:24] == $past(wd[`FINT_HI:0], 2))
      else $error("Integer part not applied to ratio");

   a_ratio_sum: assert property (dSrc_r ##1 dSrc_r
      |-> fracRatio == $past({dReg_r.fracInt, dReg_r.frac}))
      else $error("Ratio does not match stored fields");

   a_d_pin_source: assert property (!dSrc_r |=> effCfgD == $past(pinCfgD))
      else $error("Bank D not following pins");

   a_d_bank_pd: assert property (regReq.wr && regReq.addr == `ADDR_D_PWR && wd[`BIT_PD]
      ##1 dSrc_r |=> bankDOut0Off && bankDOut1HiZ)
      else $error("Bank D power-down not covering outputs");

   a_pin_keeps_reg: assert property (!cSrc_r && keepC && wrCOut0
      |=> cReg_r.amp0 == $past(wd[`AMP_HI:`AMP_LO]) && effCfgC == $past(pinCfgC))
      else $error("Register under pin control lost or applied");

   a_c_out1_pd: assert property (cSrc_r && wrCOut1 ##1 cSrc_r
      |=> bankCOut1Off == $past(wd[`BIT_PD], 2))
      else $error("Bank C output 1 power-down not applied");

   a_c_reg_source: assert property (cSrc_r ##1 cSrc_r |-> effCfgC == $past(cReg_r))
      else $error("Bank C not following registers");

   a_rd_answer: assert property (regReq.rd |=> regRdValid)
      else $error("Read not answered one cycle later");

   a_fint_rsvd_zero: assert property (regReq.rd && regReq.addr == `ADDR_FINT
      |=> regRdata[7:4] == 4'h0)
      else $error("Reserved integer byte bits not zero");

   a_frac_lo_store: assert property (regReq.wr && regReq.addr == `ADDR_FRAC_LO
      |=> dReg_r.frac[7:0] == $past(wd))
      else $error("Fraction low byte not stored");

   a_d_out0_off: assert property (dSrc_r ##1 dSrc_r
      |-> bankDOut0Off == $past(dReg_r.bankPd || dReg_r.out0Pd))
      else $error("Bank D first output power state wrong");

   a_d_out1_hiz: assert property (dSrc_r ##1 dSrc_r
      |-> bankDOut1HiZ == $past(dReg_r.bankPd || dReg_r.out1Pd))
      else $error("Bank D second output high impedance state wrong");

   a_d_pin_keeps: assert property (!dSrc_r && regReq.wr && regReq.addr == `ADDR_FRAC_LO
      |=> dReg_r.frac[7:0] == $past(wd) && effCfgD == $past(pinCfgD))
      else $error("Bank D register under pin control lost or applied");

   // Main scenarios
   c_c_to_reg: cover property (!cSrc_r ##1 cSrc_r ##[1:8] wrCOut0);
   c_d_style: cover property (dSrc_r && wrDOut0 && wd[`BIT_STY]);
   c_d_bank_off: cover property (effCfgD.bankPd && !effCfgD.out1Pd);
   c_read_frac: cover property (regReq.rd && regReq.addr == `ADDR_FRAC_MID);
   c_fint_write: cover property (dSrc_r && regReq.wr && regReq.addr == `ADDR_FINT);

endmodule : clock_output_bank_config_regs

// ### test/cfg_host_model.sv
// Host side model that issues byte accesses to the bank registers
`timescale 1ns/10ps
module cfg_host_model
   import clkbank_pkg::*;
(
   input  wire logic       clk_sys,
   output regReq_t         regReq,
   input  wire logic [7:0] regRdata,
   input  wire logic       regRdValid
);
   // ****************************
   // Byte access tasks
   // ****************************
   initial regReq = '0;

   // Writable positions of each address
   function automatic logic [7:0] keep(input logic [7:0] a);
      case (a)
         8'h22, 8'h2e:        keep = 8'h81;
         8'h24, 8'h25, 8'h30: keep = 8'h87;
         8'h2b, 8'h2d:        keep = 8'h0f;
         8'h2c:               keep = 8'h3f;
         8'h31:               keep = 8'h80;
         8'h2f:               keep = 8'h00;
         default:             keep = 8'hff;
      endcase
   endfunction : keep

   // One-cycle write strobe, changed only at falling edges
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = d & keep(a);
      if (a == 8'h2b && m < 8'h05) m = 8'h05;
      @(negedge clk_sys);
      regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: m};
      @(negedge clk_sys);
      regReq.wr = 1'b0;
      regReq.wdata = ~m;
   endtask : wr_byte

   // Read strobe; answer stands in the cycle after the taking edge
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys);
      regReq.addr = a;
      regReq.rd = 1'b1;
      @(negedge clk_sys);
      regReq.rd = 1'b0;
      d = regRdata;
      v = regRdValid;
   endtask : rd_byte
endmodule : cfg_host_model

// ### test/clock_output_bank_config_regs_tb.sv
// Self-checking bench of the bank C and bank D configuration registers
`timescale 1ns/10ps
module clock_output_bank_config_regs_tb
   import clkbank_pkg::*;
;
   // ****************************
   // Signals and table
   // ****************************
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   regReq_t     regReq;
   logic [7:0]  regRdata, rd;
   logic        regRdValid, rv;
   bankCCfg_t   pinCfgC = '{1'b0, 2'b10, 2'b01, 2'h1, 2'h2};
   bankDCfg_t   pinCfgD = '{6'h05, 4'h7, 24'habcdef, 2'h1, 1'b1, 1'b0, 1'b0, 1'b1,
                            1'b0, 1'b1, 2'h2};
   bankCCfg_t   effCfgC;
   bankDCfg_t   effCfgD;
   logic        bankCOut0Off, bankCOut1Off, bankDOut0Off, bankDOut1HiZ;
   logic [27:0] fracRatio;
   int          err_count = 0;
   int          n_compared = 0;
   typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] q;} row_t;
   // Reset values first, then writes read back
   localparam row_t ROWS [25] = '{
      '{8'h22, '0, '0, 8'h00}, '{8'h24, '0, '0, 8'h00}, '{8'h25, '0, '0, 8'h00},
      '{8'h28, '0, '0, 8'h00}, '{8'h29, '0, '0, 8'h00}, '{8'h2a, '0, '0, 8'h60},
      '{8'h2b, '0, '0, 8'h09}, '{8'h2c, '0, '0, 8'h0d}, '{8'h2d, '0, '0, 8'h00},
      '{8'h2e, '0, '0, 8'h00}, '{8'h2f, '0, '0, 8'h00}, '{8'h30, '0, '0, 8'h00},
      '{8'h31, '0, '0, 8'h00}, '{8'h24, '1, 8'h85, 8'h85}, '{8'h25, '1, 8'h06, 8'h06},
      '{8'h28, '1, 8'h56, 8'h56}, '{8'h29, '1, 8'h34, 8'h34}, '{8'h2a, '1, 8'h12, 8'h12},
      '{8'h2b, '1, 8'h0f, 8'h0f}, '{8'h2c, '1, 8'h3f, 8'h3f}, '{8'h2d, '1, 8'h0b, 8'h0b},
      '{8'h30, '1, 8'h86, 8'h86}, '{8'h31, '1, 8'h80, 8'h80}, '{8'h2f, '1, 8'hff, 8'h00},
      '{8'h40, '1, 8'hff, 8'h00}};

   always #5 clk_sys = ~clk_sys;

   clock_output_bank_config_regs i_dut (.clk_sys, .reset_n, .regReq, .regRdata,
      .regRdValid, .pinCfgC, .pinCfgD, .effCfgC, .effCfgD, .bankCOut0Off,
      .bankCOut1Off, .bankDOut0Off, .bankDOut1HiZ, .fracRatio);
   cfg_host_model i_host (.clk_sys, .regReq, .regRdata, .regRdValid);

   // ****************************
   // Compare and closing tasks
   // ****************************
   task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : cmp_byte

   task automatic cmp_word(input string n, input logic [47:0] e, input logic [47:0] s);
      n_compared++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : cmp_word

   task automatic chk_d(input logic e0, input logic e1);
      cmp_word("bankDOut0Off", 48'(e0), 48'(bankDOut0Off));
      cmp_word("bankDOut1HiZ", 48'(e1), 48'(bankDOut1HiZ));
   endtask : chk_d

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // ****************************
   // Test sequence
   // ****************************
   initial
   begin
      #50us;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      foreach (ROWS[i])
      begin
         if (ROWS[i].w) i_host.wr_byte(ROWS[i].a, ROWS[i].d);
         i_host.rd_byte(ROWS[i].a, rd, rv);
         cmp_byte("regRdata", ROWS[i].q, rd);
         cmp_word("regRdValid", 48'(1), 48'(rv));
      end
      // Pin control ignores the written registers
      cmp_word("effCfgC", 48'(pinCfgC), 48'(effCfgC));
      cmp_word("effCfgD", 48'(pinCfgD), 48'(effCfgD));
      cmp_word("fracRatio", 48'(28'h7abcdef), 48'(fracRatio));
      cmp_word("bankCOut1Off", 48'(1), 48'(bankCOut1Off));
      chk_d(1'b1, 1'b0);
      // Bank C under register control
      i_host.wr_byte(8'h22, 8'h81);
      @(negedge clk_sys);
      cmp_word("effCfgC", 48'(bankCCfg_t'{1'b1, 2'b01, 2'b11, 2'h2, 2'h1}),
         48'(effCfgC));
      cmp_word("bankCOut0Off", 48'(1), 48'(bankCOut0Off));
      for (int k = 0; k < 3; k++)
      begin
         i_host.wr_byte(8'h24, {k[0], 4'h0, k[0], k[1:0]});
         @(negedge clk_sys);
         cmp_word("amp0", 48'(k[1:0]), 48'(effCfgC.amp0));
         cmp_word("sty0", 48'(k[0]), 48'(effCfgC.sty[0]));
         cmp_word("bankCOut0Off", 48'(k[0]), 48'(bankCOut0Off));
      end
      i_host.wr_byte(8'h25, 8'h80);
      @(negedge clk_sys);
      cmp_word("bankCOut1Off", 48'(1), 48'(bankCOut1Off));
      // Bank D under register control
      i_host.wr_byte(8'h2e, 8'h01);
      @(negedge clk_sys);
      cmp_word("effCfgD", 48'(bankDCfg_t'{6'h3f, 4'hf, 24'h123456, 2'h2, 1'b1, 1'b1, 1'b0,
         1'b1, 1'b1, 1'b1, 2'h2}), 48'(effCfgD));
      cmp_word("fracRatio", 48'(28'hf123456), 48'(fracRatio));
      chk_d(1'b1, 1'b1);
      i_host.wr_byte(8'h28, 8'h00);
      i_host.wr_byte(8'h2b, 8'h0a);
      @(negedge clk_sys);
      cmp_word("fracRatio", 48'(28'ha123400), 48'(fracRatio));
      i_host.wr_byte(8'h30, 8'h06);
      i_host.wr_byte(8'h31, 8'h00);
      @(negedge clk_sys);
      chk_d(1'b0, 1'b0);
      i_host.wr_byte(8'h2e, 8'h81);
      @(negedge clk_sys);
      chk_d(1'b1, 1'b1);
      // Reset in mid-run returns both banks to pin control
      reset_n = 1'b0;
      @(negedge clk_sys);
      cmp_word("effCfgC", 48'(0), 48'(effCfgC));
      cmp_word("effCfgD", 48'(0), 48'(effCfgD));
      reset_n = 1'b1;
      @(negedge clk_sys);
      cmp_word("effCfgC", 48'(pinCfgC), 48'(effCfgC));
      // Pins that change under pin control reach the applied settings
      pinCfgC = ~pinCfgC;
      pinCfgD = ~pinCfgD;
      @(negedge clk_sys);
      cmp_word("effCfgC", 48'(pinCfgC), 48'(effCfgC));
      cmp_word("effCfgD", 48'(pinCfgD), 48'(effCfgD));
      i_host.rd_byte(8'h22, rd, rv);
      cmp_byte("regRdata", 8'h00, rd);
      i_host.rd_byte(8'h2a, rd, rv);
      cmp_byte("regRdata", 8'h60, rd);
      tally_and_finish();
   end
endmodule : clock_output_bank_config_regs_tb
